/* File: nfc_pkg.sv */
// constants, types and register map of the nor flash command controller
package nfc_pkg;

	localparam int CLK_NS      = 50;
	localparam int WE_GLITCH_NS = 5;
	localparam int PROG_MAX_NS = 20_000;
	localparam int SETTLE_NS   = 1_000;

	localparam int WE_CYC_I   = (WE_GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] WE_CYC = 8'((WE_CYC_I < 1) ? 1 : WE_CYC_I);
	localparam int PROG_LIMIT_DEF = PROG_MAX_NS / CLK_NS;
	localparam int SETTLE_CYC_I   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [15:0] SETTLE_CYC = 16'(SETTLE_CYC_I);
	localparam logic [1:0] RECHECK_READS = 2'd2;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int SECTOR_LSB = 11;
	localparam int BLOCK_LSB  = 15;

	localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 20'h0_5555;
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 20'h0_2AAA;
	localparam logic [DATA_W-1:0] CODE_UNLOCK1 = 16'h00AA;
	localparam logic [DATA_W-1:0] CODE_UNLOCK2 = 16'h0055;
	localparam logic [DATA_W-1:0] CODE_PROGRAM = 16'h00A0;
	localparam logic [DATA_W-1:0] CODE_ERASE   = 16'h0080;
	localparam logic [DATA_W-1:0] CODE_ID      = 16'h0090;
	localparam logic [DATA_W-1:0] CODE_CFI     = 16'h0098;
	localparam logic [DATA_W-1:0] CODE_EXIT    = 16'h00F0;
	localparam logic [DATA_W-1:0] CODE_SECTOR  = 16'h0030;
	localparam logic [DATA_W-1:0] CODE_BLOCK   = 16'h0050;
	localparam logic [DATA_W-1:0] CODE_CHIP    = 16'h0010;

	localparam logic [2:0] LAST_PROG  = 3'd3;
	localparam logic [2:0] LAST_ERASE = 3'd5;
	localparam logic [2:0] LAST_ENTRY = 3'd2;
	localparam logic [2:0] LAST_EXIT  = 3'd0;
	localparam logic [2:0] IDX_CMD    = 3'd2;
	localparam logic [2:0] IDX_DATA   = 3'd3;
	localparam logic [2:0] IDX_FINAL  = 3'd5;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_ID   = 3;
	localparam int ST_CFI  = 4;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		OP_READ = 3'h0, OP_PROGRAM = 3'h1, OP_SECTOR = 3'h2, OP_BLOCK = 3'h3,
		OP_CHIP = 3'h4, OP_ID = 3'h5, OP_CFI = 3'h6, OP_EXIT = 3'h7
	} nfc_op_t;

	typedef struct packed {
		logic              isWrite;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} nfc_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic              dqOe;
		logic              ceN;
		logic              oeN;
		logic              weN;
	} nfc_pins_t;

	localparam nfc_pins_t PINS_IDLE = '{addr: '0, dq: '0, dqOe: 1'b0,
		ceN: 1'b1, oeN: 1'b1, weN: 1'b1};

endpackage

/* File: nfc_bus_cycle.sv */
// one asynchronous read or write cycle at the flash pins
`timescale 1ns/1ns
module nfc_bus_cycle import nfc_pkg::*; #(
	parameter int READ_CYC = 2
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              start,
	input  wire nfc_req_t          req,
	output logic                   busy,
	output logic                   done,
	output logic [DATA_W-1:0]      rdData,
	output nfc_pins_t              pins,
	input  wire logic [DATA_W-1:0] dqIn
);
	generate
		if (READ_CYC < 1 || READ_CYC > 255) begin : g_bad
			$error("READ_CYC out of range");
		end
	endgenerate

	typedef enum logic [3:0] {
		C_IDLE = 4'b0001, C_SETUP = 4'b0010, C_STROBE = 4'b0100, C_HOLD = 4'b1000
	} nfc_cyc_t;

	nfc_cyc_t   state_q;
	logic       isWr_q;
	logic [7:0] cnt_q;

	wire [7:0] cntNext = cnt_q + 8'd1;
	wire [7:0] limit   = isWr_q ? WE_CYC : 8'(READ_CYC);
	wire       strobeEnd = (cntNext >= limit);
	assign busy = (state_q != C_IDLE);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= C_IDLE;
			pins    <= PINS_IDLE;
			isWr_q  <= 1'b0;
			cnt_q   <= 8'h00;
			done    <= 1'b0;
			rdData  <= '0;
		end else begin
			done <= 1'b0;
			case (state_q)
				C_IDLE: if (start) begin
					pins.addr <= req.addr;
					pins.dq   <= req.data;
					pins.ceN  <= 1'b0;
					pins.oeN  <= req.isWrite;
					pins.dqOe <= req.isWrite;
					isWr_q    <= req.isWrite;
					state_q   <= C_SETUP;
				end
				C_SETUP: begin
					pins.weN <= ~isWr_q;
					cnt_q    <= 8'h00;
					state_q  <= C_STROBE;
				end
				C_STROBE: begin
					cnt_q <= cntNext;
					if (strobeEnd) begin
						pins.weN <= 1'b1;
						if (!isWr_q) rdData <= dqIn;
						state_q <= C_HOLD;
					end
				end
				C_HOLD: begin
					pins.ceN  <= 1'b1;
					pins.oeN  <= 1'b1;
					pins.dqOe <= 1'b0;
					done      <= 1'b1;
					state_q   <= C_IDLE;
				end
				default: state_q <= C_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	chk_write_inhibit_ok: assert property (!pins.weN |-> pins.oeN && !pins.ceN)
		else $error("write strobe low with output enable low or chip deselected");
	chk_dq_no_fight: assert property (!pins.oeN |-> !pins.dqOe)
		else $error("host drives data while flash output enabled");
	chk_data_at_rise: assert property ($rose(pins.weN) |-> pins.dqOe && !pins.ceN)
		else $error("data or chip select released before write strobe rise");
endmodule

/* File: nfc_sequencer.sv */
// axi4-lite controlled command sequencer for an x16 parallel nor flash
// How it works
// - address latched at later falling edge, data at earlier rising edge of ce/we.
// - after polling shows completion, wait 1 us before trusting the word.
// - after apparent completion re-read twice; accept only if both agree.
// - query mode entered with 98h at 5555h; left with the exit command.
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module nfc_sequencer import nfc_pkg::*; #(
	parameter int READ_CYC       = 2,
	parameter int PROG_LIMIT_CYC = PROG_LIMIT_DEF
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output nfc_pins_t              flashPins,
	input  wire logic [DATA_W-1:0] flashDqIn
);
	generate
		if (PROG_LIMIT_CYC < 1 || PROG_LIMIT_CYC > 65535) begin : g_bad
			$error("PROG_LIMIT_CYC out of range");
		end
	endgenerate

	localparam logic [15:0] PROG_LIMIT = 16'(PROG_LIMIT_CYC);

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001, S_WRITE = 5'b00010, S_POLL = 5'b00100,
		S_SETTLE = 5'b01000, S_READ = 5'b10000
	} nfc_state_t;

	// axi slave
	logic              awHave_q, wHave_q;
	logic [7:0]        awAddr_q;
	logic [31:0]       wData_q;
	logic [3:0]        wStrb_q;
	// sequencer
	nfc_state_t        state_q, state_d;
	nfc_op_t           op_q;
	logic [2:0]        idx_q;
	logic              issued_q;
	logic [ADDR_W-1:0] tgtAddr_q;
	logic [DATA_W-1:0] wdata_q, rdata_q;
	logic              done_q, fail_q, idMode_q, cfiMode_q;
	logic              prevDq6_q, havePrev_q;
	logic [1:0]        stable_q;
	logic [15:0]       timer_q;
	logic              engBusy, engDone;
	logic [DATA_W-1:0] engRd;
	nfc_req_t          stepReq;

	function automatic logic [31:0] mergeBytes(logic [31:0] old, logic [31:0] nw,
		logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// command step table; upper data byte always zero in protected steps
	function automatic nfc_req_t stepOf(nfc_op_t op, logic [2:0] idx,
		logic [ADDR_W-1:0] ta, logic [DATA_W-1:0] td);
		nfc_req_t r;
		r.isWrite = 1'b1;
		r.addr    = ADDR_UNLOCK1;
		r.data    = CODE_UNLOCK1;
		if (idx == 3'd1 || idx == 3'd4) begin
			r.addr = ADDR_UNLOCK2;
			r.data = CODE_UNLOCK2;
		end else if (idx == IDX_CMD) begin
			r.data = (op == OP_PROGRAM) ? CODE_PROGRAM : (op == OP_ID) ? CODE_ID :
				(op == OP_CFI) ? CODE_CFI : CODE_ERASE;
		end else if (idx == IDX_DATA && op == OP_PROGRAM) begin
			r.addr = ta;
			r.data = td;
		end else if (idx == IDX_FINAL) begin
			if (op == OP_SECTOR) begin
				r.addr = {ta[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
				r.data = CODE_SECTOR;
			end else if (op == OP_BLOCK) begin
				r.addr = {ta[ADDR_W-1:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
				r.data = CODE_BLOCK;
			end else begin
				r.data = CODE_CHIP;
			end
		end
		if (op == OP_EXIT) begin
			r.addr = ta;
			r.data = CODE_EXIT;
		end
		return r;
	endfunction

	// axi decode
	wire wrFire   = awHave_q && wHave_q && !s_axi_bvalid;
	wire wrCtrl   = wrFire && (awAddr_q == REG_CTRL);
	wire wrAddr   = wrFire && (awAddr_q == REG_ADDR);
	wire wrData   = wrFire && (awAddr_q == REG_WDATA);
	wire wrRo     = (awAddr_q == REG_STATUS) || (awAddr_q == REG_RDATA);
	wire wrMapped = wrCtrl || wrAddr || wrData || wrRo;
	wire rdFire   = s_axi_arvalid && s_axi_arready;
	wire [4:0] statusWord = {cfiMode_q, idMode_q, fail_q, done_q,
		(state_q != S_IDLE) || engBusy};
	wire [31:0] rdCtrl   = {29'h0000_0000, op_q};
	wire [31:0] rdAddr   = {{(32-ADDR_W){1'b0}}, tgtAddr_q};
	wire [31:0] rdWdata  = {16'h0000, wdata_q};
	wire [31:0] rdStatus = {27'h000_0000, statusWord};
	wire [31:0] rdRdata  = {16'h0000, rdata_q};
	wire [31:0] rdSel;
	wire        rdHit;
	assign rdSel = (s_axi_araddr == REG_CTRL) ? rdCtrl :
		(s_axi_araddr == REG_ADDR) ? rdAddr : (s_axi_araddr == REG_WDATA) ? rdWdata :
		(s_axi_araddr == REG_STATUS) ? rdStatus :
		(s_axi_araddr == REG_RDATA) ? rdRdata : 32'h0000_0000;
	assign rdHit = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_ADDR) ||
		(s_axi_araddr == REG_WDATA) || (s_axi_araddr == REG_STATUS) ||
		(s_axi_araddr == REG_RDATA);
	assign s_axi_awready = !awHave_q && !s_axi_bvalid;
	assign s_axi_wready  = !wHave_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			awHave_q <= 1'b0;
			wHave_q  <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end else if (wrFire) awHave_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end else if (wrFire) wHave_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
		end else begin
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
			if (rdFire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdSel;
				s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
		end
	end

	// sequencer decode
	// a read cut by a timeout may still be running in the engine
	wire     isIdle   = (state_q == S_IDLE) && !engBusy;
	wire     startCmd = wrCtrl && wStrb_q[0] && isIdle;
	nfc_op_t newOp;
	assign newOp = nfc_op_t'(wData_q[2:0]);
	wire isErase = (op_q == OP_SECTOR) || (op_q == OP_BLOCK) || (op_q == OP_CHIP);
	wire pollOp  = (op_q == OP_PROGRAM) || isErase;
	wire [2:0] lastIdx = (op_q == OP_PROGRAM) ? LAST_PROG : isErase ? LAST_ERASE :
		(op_q == OP_EXIT) ? LAST_EXIT : LAST_ENTRY;
	wire stepDone = (state_q == S_WRITE) && engDone && (idx_q == lastIdx);
	wire dq7Ok    = (op_q == OP_PROGRAM) ? (engRd[7] == wdata_q[7]) : engRd[7];
	wire match    = havePrev_q && (engRd[6] == prevDq6_q) && dq7Ok;
	wire pollDone = (state_q == S_POLL) && engDone && match && (stable_q == RECHECK_READS);
	wire timedOut = (state_q == S_POLL) && (op_q == OP_PROGRAM) &&
		(timer_q == PROG_LIMIT - 16'd1);
	wire engStart = ((state_q == S_WRITE) || (state_q == S_POLL) || (state_q == S_READ)) &&
		!issued_q && !engBusy;
	nfc_req_t engReq;
	assign stepReq = stepOf(op_q, idx_q, tgtAddr_q, wdata_q);
	assign engReq  = (state_q == S_WRITE) ? stepReq :
		'{isWrite: 1'b0, addr: tgtAddr_q, data: '0};

	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE:   if (startCmd) state_d = (newOp == OP_READ) ? S_READ : S_WRITE;
			S_WRITE:  if (stepDone) state_d = pollOp ? S_POLL : S_IDLE;
			S_POLL:   if (timedOut) state_d = S_IDLE;
				else if (pollDone) state_d = S_SETTLE;
			S_SETTLE: if (timer_q == SETTLE_CYC - 16'd1) state_d = S_IDLE;
			S_READ:   if (engDone) state_d = S_IDLE;
			default:  state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q  <= S_IDLE;
			timer_q  <= 16'h0000;
			issued_q <= 1'b0;
			idx_q    <= 3'd0;
		end else begin
			state_q  <= state_d;
			timer_q  <= (state_d != state_q) ? 16'h0000 : timer_q + 16'd1;
			issued_q <= engStart ? 1'b1 : engDone ? 1'b0 : issued_q;
			if (startCmd) idx_q <= 3'd0;
			else if (state_q == S_WRITE && engDone) idx_q <= idx_q + 3'd1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			op_q       <= OP_READ;
			tgtAddr_q  <= '0;
			wdata_q    <= '0;
			rdata_q    <= '0;
		end else begin
			if (isIdle && wrCtrl && wStrb_q[0]) op_q <= newOp;
			if (wrAddr) tgtAddr_q <= ADDR_W'(mergeBytes(rdAddr, wData_q, wStrb_q));
			if (wrData) wdata_q <= DATA_W'(mergeBytes(rdWdata, wData_q, wStrb_q));
			if (state_q == S_READ && engDone) rdata_q <= engRd;
		end
	end

	// toggle and polling bit tracking
	always_ff @(posedge core_clk) begin
		if (reset || startCmd) begin
			prevDq6_q  <= 1'b0;
			havePrev_q <= 1'b0;
			stable_q   <= 2'd0;
		end else if (state_q == S_POLL && engDone) begin
			prevDq6_q  <= engRd[6];
			havePrev_q <= 1'b1;
			stable_q   <= match ? stable_q + 2'd1 : 2'd0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			done_q    <= 1'b0;
			fail_q    <= 1'b0;
			idMode_q  <= 1'b0;
			cfiMode_q <= 1'b0;
		end else begin
			if (state_q != S_IDLE && state_d == S_IDLE) done_q <= 1'b1;
			else if (startCmd) done_q <= 1'b0;
			if (timedOut) fail_q <= 1'b1;
			else if (startCmd) fail_q <= 1'b0;
			if (stepDone && op_q == OP_ID) idMode_q <= 1'b1;
			if (stepDone && op_q == OP_CFI) cfiMode_q <= 1'b1;
			if (stepDone && op_q == OP_EXIT) begin
				idMode_q  <= 1'b0;
				cfiMode_q <= 1'b0;
			end
		end
	end

	nfc_bus_cycle #(.READ_CYC(READ_CYC)) u_cycle (
		.core_clk (core_clk),
		.reset    (reset),
		.start    (engStart),
		.req      (engReq),
		.busy     (engBusy),
		.done     (engDone),
		.rdData   (engRd),
		.pins     (flashPins),
		.dqIn     (flashDqIn)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_lastWrite;
		stepDone && pollOp;
	endsequence
	chk_poll_after_last: assert property (s_lastWrite |=> state_q == S_POLL)
		else $error("polling did not follow the last command write");
	chk_settle_length: assert property ($rose(state_q == S_SETTLE) |->
		(state_q == S_SETTLE)[*8])
		else $error("settle wait ended early");
	chk_settle_exit: assert property (state_q == S_SETTLE && state_d != S_SETTLE |->
		timer_q == SETTLE_CYC - 16'd1)
		else $error("settle wait not the full interval");
	chk_prog_timeout: assert property (timedOut |=> fail_q && state_q == S_IDLE)
		else $error("program overrun not flagged");
	chk_upper_zero: assert property (engStart && state_q == S_WRITE &&
		!(op_q == OP_PROGRAM && idx_q == IDX_DATA) |-> engReq.data[15:8] == 8'h00)
		else $error("upper byte not zero in command write");
	chk_unlock_first: assert property (engStart && state_q == S_WRITE && idx_q == 3'd0 &&
		op_q != OP_EXIT |-> engReq.addr == ADDR_UNLOCK1 && engReq.data == CODE_UNLOCK1)
		else $error("sequence does not open with the unlock write");
	chk_confirm_reads: assert property (state_q == S_POLL ##1 state_q == S_SETTLE |->
		$past(stable_q) == RECHECK_READS)
		else $error("completion accepted without two confirming reads");
endmodule

/* File: nfc_flash_model.sv */
// behavioural x16 nor flash answering the sequencer's pins
`timescale 1ns/1ns
module nfc_flash_model import nfc_pkg::*; #(
	parameter logic [15:0] MAKER_CODE  = 16'h0000, // arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h0000, // arbitrary value
	parameter int          PROG_CYC    = 8,
	parameter int          SLOW_CYC    = 80,
	parameter int          ERASE_CYC   = 30
) (
	input  wire logic              core_clk,
	input  wire nfc_pins_t         pins,
	input  wire logic              slow,
	output logic [DATA_W-1:0]      dqOut
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0] addrLat;
	logic [DATA_W-1:0] progData = '0;
	logic              wrOpen = 1'b0, isProg = 1'b0, tog = 1'b0, idMode = 1'b0, cfiMode = 1'b0;
	int                step = 0, busyCnt = 0;
	time               tFall = 0, settleEnd = 0;

	initial begin
		foreach (mem[i]) mem[i] = '1;
		dqOut = '0;
	end

	// internal operation timer; low bits stay unsettled 1 us after the end
	always @(posedge core_clk) begin
		if (busyCnt == 1) settleEnd = $time + 1000;
		if (busyCnt != 0) busyCnt = busyCnt - 1;
	end

	task automatic start_op(input logic prog);
		isProg = prog;
		busyCnt = !prog ? ERASE_CYC : slow ? SLOW_CYC : PROG_CYC;
	endtask

	task automatic take_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [7:0] c;
		logic       u1, u2, at5;
		int         n;
		c = d[7:0];
		at5 = a[14:0] == 15'h5555;
		u1 = at5 && c == 8'hAA;
		u2 = a[14:0] == 15'h2AAA && c == 8'h55;
		n = 0;
		if (busyCnt != 0) return;
		if (step != 3 && c == 8'hF0) begin
			idMode = 1'b0;
			cfiMode = 1'b0;
			step = 0;
			return;
		end
		case (step)
			0: step = u1 ? 1 : 0;
			1: step = u2 ? 2 : 0;
			2: begin
				idMode |= at5 && c == 8'h90;
				cfiMode |= at5 && c == 8'h98;
				step = !at5 ? 0 : c == 8'hA0 ? 3 : c == 8'h80 ? 4 : 0;
			end
			3: begin
				mem[a] = mem[a] & d;
				progData = d;
				start_op(1'b1);
				step = 0;
			end
			4: step = u1 ? 5 : 0;
			5: step = u2 ? 6 : 0;
			default: begin
				n = c == 8'h30 ? 1 << 11 : c == 8'h50 ? 1 << 15 : (at5 && c == 8'h10) ? 1 << ADDR_W : 0;
				for (int i = 0; i < n; i++) mem[ADDR_W'((int'(a) & ~(n - 1)) + i)] = '1;
				if (n != 0) start_op(1'b0);
				step = 0;
			end
		endcase
	endtask

	// address at the later falling edge, data at the earlier rising edge
	always @(negedge pins.weN or negedge pins.ceN) begin
		if (!pins.weN && !pins.ceN && pins.oeN) begin
			addrLat = pins.addr;
			tFall = $time;
			wrOpen = 1'b1;
		end
	end
	always @(posedge pins.weN or posedge pins.ceN) begin
		if (wrOpen) begin
			wrOpen = 1'b0;
			if ($time - tFall >= 5) take_write(addrLat, pins.dq);
		end
	end

	// one event per read even when both selects move in the same step
	wire rdOn = !pins.oeN && !pins.ceN;
	always @(posedge rdOn) begin
		if (busyCnt != 0) tog = ~tog;
		dqOut = busyCnt != 0 ? {8'h00, isProg & ~progData[7], tog, 6'h00}
			: idMode ? (pins.addr == 0 ? MAKER_CODE : pins.addr == 1 ? DEVICE_CODE : '0)
			: cfiMode ? (pins.addr == 20'h0_0010 ? 16'h0051 : '0)
			: mem[pins.addr] ^ ($time < settleEnd ? 16'h003F : 16'h0000);
	end
	// released bus shows the inverse of the last word
	always @(negedge rdOn) dqOut = ~dqOut;
endmodule

/* File: nfc_sequencer_bench.sv */
// self-checking bench of the sequencer against the behavioural flash
`timescale 1ns/1ns
module nfc_sequencer_bench import nfc_pkg::*; ();
	localparam logic [15:0] MAKER_CODE  = 16'h3C5A; // arbitrary value
	localparam logic [15:0] DEVICE_CODE = 16'h6B1E; // arbitrary value

	logic             core_clk = 1'b0, reset = 1'b1, slow = 1'b0;
	logic [7:0]       awAddr = '0, arAddr = '0;
	logic             awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic [31:0]      wData = '0, st, rd;
	logic [1:0]       rsp, wrsp;
	wire              awReady, wReady, bValid, arReady, rValid;
	wire [1:0]        bResp, rResp;
	wire [31:0]       rData;
	nfc_pins_t        pins;
	wire [DATA_W-1:0] modelDq, dqIn;
	int               n_fail = 0, n_compared = 0;
	logic [31:0]      wa [4] = '{32'h0000_0123, 32'h0000_07FF, 32'h0000_0800, 32'h0000_8000};
	logic [31:0]      wd [4] = '{32'h0000_5A3C, 32'h0000_A5C1, 32'h0000_0F82, 32'h0000_7003};
	logic [31:0]      ea [3] = '{32'h0000_0123, 32'h0000_4567, 32'h0000_5555};
	nfc_op_t          eo [3] = '{OP_SECTOR, OP_BLOCK, OP_CHIP};

	always #25 core_clk = ~core_clk;
	assign dqIn = pins.dqOe ? pins.dq : modelDq;

	nfc_sequencer #(.READ_CYC(2), .PROG_LIMIT_CYC(40)) dut (
		.core_clk(core_clk), .reset(reset),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.flashPins(pins), .flashDqIn(dqIn));
	nfc_flash_model #(.MAKER_CODE(MAKER_CODE), .DEVICE_CODE(DEVICE_CODE)) flash (
		.core_clk(core_clk), .pins(pins), .slow(slow), .dqOut(modelDq));

	task automatic report_and_stop();
		$display("compared %0d wrong %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic give_up();
		n_fail++;
		report_and_stop();
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		int   k;
		logic aw, w;
		k = 0;
		aw = 1'b1;
		w = 1'b1;
		@(posedge core_clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		while ((aw || w) && k < 50) begin
			@(posedge core_clk);
			k++;
			if (aw && awReady === 1'b1) begin
				aw = 1'b0;
				awValid <= 1'b0;
			end
			if (w && wReady === 1'b1) begin
				w = 1'b0;
				wValid <= 1'b0;
			end
		end
		do begin
			@(posedge core_clk);
			k++;
		end while (bValid !== 1'b1 && k < 50);
		wrsp = bResp;
		bReady <= 1'b0;
		if (k >= 50) give_up();
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		k = 0;
		@(posedge core_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (arReady !== 1'b1 && k < 50);
		arValid <= 1'b0;
		do begin
			@(posedge core_clk);
			k++;
		end while (rValid !== 1'b1 && k < 50);
		d = rData;
		r = rResp;
		rReady <= 1'b0;
		if (k >= 50) give_up();
	endtask

	task automatic wait_idle();
		int k;
		repeat (2) @(posedge core_clk);
		for (k = 0; k < 400; k++) begin
			axi_read(REG_STATUS, st, rsp);
			if (st[ST_BUSY] === 1'b0) break;
		end
		if (k >= 400) give_up();
	endtask

	task automatic run_op(input nfc_op_t op);
		axi_write(REG_CTRL, 32'(op));
		wait_idle();
	endtask

	task automatic prog(input logic [31:0] a, input logic [31:0] d);
		axi_write(REG_ADDR, a);
		axi_write(REG_WDATA, d);
		run_op(OP_PROGRAM);
	endtask

	task automatic rd_check(input logic [31:0] a, input logic [15:0] exp);
		axi_write(REG_ADDR, a);
		run_op(OP_READ);
		axi_read(REG_RDATA, rd, rsp);
		check("flash word", rd, {16'h0000, exp});
	endtask

	// pin discipline watched every cycle
	always @(posedge core_clk) begin
		if (!reset && pins.ceN === 1'b0 && pins.oeN === 1'b0) check("host drive", pins.dqOe, 0);
		if (!reset && pins.weN === 1'b0) check("oe in write", pins.oeN, 1);
	end

	initial begin
		int i, s;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		axi_read(REG_STATUS, st, rsp);
		check("reset status", st, 32'h0000_0000);
		check("ce idle", pins.ceN, 32'h0000_0001);
		axi_read(8'h14, rd, rsp);
		check("unmapped resp", rsp, RESP_SLVERR);
		check("unmapped data", rd, 32'h0000_0000);
		axi_write(8'h14, 32'h0000_0001);
		check("unmapped wr resp", wrsp, RESP_SLVERR);
		axi_write(REG_WDATA, 32'hFFFF_5A3C);
		check("mapped wr resp", wrsp, RESP_OKAY);
		axi_read(REG_WDATA, rd, rsp);
		check("wdata readback", rd, 32'h0000_5A3C);
		check("mapped rd resp", rsp, RESP_OKAY);
		axi_write(REG_ADDR, 32'hFFFF_FFFF);
		axi_read(REG_ADDR, rd, rsp);
		check("addr readback", rd, 32'h000F_FFFF);
		rd_check(32'h0000_0123, 16'hFFFF);
		for (i = 0; i < 4; i++) begin
			prog(wa[i], wd[i]);
			check("program status", st[2:0], 32'h0000_0002);
		end
		for (i = 0; i < 4; i++) rd_check(wa[i], wd[i][15:0]);
		// chip erase ordered while a program runs must be ignored
		axi_write(REG_ADDR, 32'h0000_0124);
		axi_write(REG_WDATA, 32'h0000_1234);
		axi_write(REG_CTRL, 32'(OP_PROGRAM));
		axi_write(REG_CTRL, 32'(OP_CHIP));
		wait_idle();
		rd_check(32'h0000_0124, 16'h1234);
		rd_check(wa[3], wd[3][15:0]);
		for (s = 0; s < 3; s++) begin
			axi_write(REG_ADDR, ea[s]);
			run_op(eo[s]);
			check("erase status", st[2:0], 32'h0000_0002);
			for (i = 0; i < 4; i++) rd_check(wa[i], i < s + 2 ? 16'hFFFF : wd[i][15:0]);
		end
		run_op(OP_ID);
		check("id flag", st[ST_ID], 1);
		axi_read(REG_CTRL, rd, rsp);
		check("ctrl readback", rd, 32'(OP_ID));
		rd_check(32'h0000_0000, MAKER_CODE);
		rd_check(32'h0000_0001, DEVICE_CODE);
		run_op(OP_EXIT);
		check("id flag", st[ST_ID], 0);
		rd_check(32'h0000_0000, 16'hFFFF);
		run_op(OP_CFI);
		check("cfi flag", st[ST_CFI], 1);
		rd_check(32'h0000_0010, 16'h0051);
		run_op(OP_EXIT);
		check("cfi flag", st[ST_CFI], 0);
		slow <= 1'b1;
		prog(32'h0000_0200, 32'h0000_0011);
		check("program timeout", st[2:0], 32'h0000_0006);
		report_and_stop();
	end
endmodule
